// *** design/ebm_monitor.sv ***
// Purpose: Error burst rate monitor, byte error counting, frame CRC check and far-end loopback control
// Assumes: Inputs synchronous to sys_clk; OOB detector and link layer flag events as pulses
// Notes: Times run on a millisecond tick from a programmable prescaler
`timescale 1ns/10ps
`default_nettype none
// Function
// - A window of about 1.5 s holding invalid words is one burst.
// - Each burst window adds exactly one to the burst counter.
// - Flag threshold when fifteen bursts occur within five minutes.
// - Five-minute timer accurate to plus or minus 0.3 s.
// - Burst counting restarts from zero on entering link ready.
// - After a detection, fifteen more bursts needed before the next.
// - Counting may restart whenever the five-minute period expires.
// - Each corrupted character, mismatch or code violation, counts one byte error.
// - Byte-wise bit error rate should stay below ten to minus twelve.
// - Check each frame CRC and report failures upward.
// - Retimed loopback entered only on a BIST FIS request.
// - Retimed loopback runs CRC-clean at least 1000 ms at Gen1.
// - Stay in retimed loopback until COMRESET or COMINIT is received; the code also leaves it on a transmit-only BIST request.
// - BIST FIS selects transmit-only mode sending repeated patterns.
// - Analog loopback modes are vendor options with no test requirement.
// - Link ready only with communication, receive sync and valid transmit.
// - Raise reset-detected when peer reset or init OOB is seen.
module ebm_monitor (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire ebm_pkg::ebm_phy_st_t phy_st,
  input wire ebm_pkg::ebm_rx_err_t rx_err,
  input wire ebm_pkg::ebm_frame_t frame,
  input wire logic oob_reset_seen,
  input wire logic bist_valid,
  input wire ebm_pkg::ebm_bist_t bist_req,
  input wire logic [15:0] tick_div,
  input wire logic [11:0] burst_ticks,
  input wire logic [18:0] period_ticks,
  input wire logic restart_on_period,
  input wire logic thresh_clr,
  output logic link_ready_indication,
  output logic reset_detected,
  output logic thresh_flag,
  output logic [4:0] burst_count,
  output logic [31:0] byte_err_count,
  output logic crc_fail,
  output logic retimed_loopback,
  output logic tx_only,
  output logic loopback_pass
);
  import ebm_pkg::*;

  // ------------------------------------------------------------
  // Link ready and OOB reset
  // ------------------------------------------------------------
  logic rdy_d;
  logic rdy_rise;
  assign rdy_d = phy_st.comm_est & phy_st.rx_sync & phy_st.tx_valid;
  assign rdy_rise = rdy_d & ~link_ready_indication;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      link_ready_indication <= 1'b0;
    end else begin
      link_ready_indication <= rdy_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reset_detected <= 1'b0;
    end else begin
      reset_detected <= oob_reset_seen;
    end
  end

  // ------------------------------------------------------------
  // Prescaled millisecond tick
  // ------------------------------------------------------------
  logic tick;
  ebm_tick #(.W(16)) u_tick (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clr(rdy_rise),
    .reload(tick_div),
    .tick(tick)
  );

  // ------------------------------------------------------------
  // Burst window: first invalid word opens it, rest are absorbed
  // ------------------------------------------------------------
  logic win_open_q;
  logic [11:0] win_cnt_q;
  logic burst_start;
  assign burst_start = rx_err.invalid_word & ~win_open_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n || rdy_rise) begin
      win_open_q <= 1'b0;
      win_cnt_q <= '0;
    end else if (burst_start) begin
      win_open_q <= 1'b1;
      win_cnt_q <= '0;
    end else if (win_open_q && tick) begin
      if (win_cnt_q + 12'h001 >= burst_ticks) begin
        win_open_q <= 1'b0;
      end
      win_cnt_q <= win_cnt_q + 12'h001;
    end
  end

  // ------------------------------------------------------------
  // Five-minute period timer, tick accurate to 1 ms
  // ------------------------------------------------------------
  logic [18:0] per_cnt_q;
  logic per_expire;
  assign per_expire = tick && (per_cnt_q + 19'h00001 >= period_ticks);

  always_ff @(posedge sys_clk) begin
    if (!rst_n || rdy_rise) begin
      per_cnt_q <= '0;
    end else if (per_expire) begin
      per_cnt_q <= '0;
    end else if (tick) begin
      per_cnt_q <= per_cnt_q + 19'h00001;
    end
  end

  // ------------------------------------------------------------
  // Burst counter and threshold
  // Count restarts after a detection so fifteen new bursts are needed.
  // ------------------------------------------------------------
  logic hit;
  assign hit = burst_start && (burst_count == THRESH_COUNT - 5'h01);

  always_ff @(posedge sys_clk) begin
    if (!rst_n || rdy_rise) begin
      burst_count <= '0;
    end else if (hit) begin
      burst_count <= '0;
    end else if (per_expire && restart_on_period) begin
      burst_count <= burst_start ? 5'h01 : 5'h00;
    end else if (burst_start && burst_count != BURST_CNT_MAX) begin
      burst_count <= burst_count + 5'h01;
    end
  end

  // Set wins over a software clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      thresh_flag <= 1'b0;
    end else if (hit) begin
      thresh_flag <= 1'b1;
    end else if (thresh_clr) begin
      thresh_flag <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Byte error count for rate computation, saturating
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      byte_err_count <= '0;
    end else if ((rx_err.byte_mismatch || rx_err.code_violation) && byte_err_count != BYTE_ERR_MAX) begin
      byte_err_count <= byte_err_count + 32'h00000001;
    end
  end

  // ------------------------------------------------------------
  // Frame CRC reporting
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      crc_fail <= 1'b0;
    end else begin
      crc_fail <= frame.frame_end & frame.crc_bad;
    end
  end

  // ------------------------------------------------------------
  // BIST modes; OOB reset has priority over a new request
  // ------------------------------------------------------------
  logic lb_exit;
  assign lb_exit = oob_reset_seen || (bist_valid && bist_req == EBM_BIST_TXONLY);

  always_ff @(posedge sys_clk) begin
    if (!rst_n || oob_reset_seen) begin
      retimed_loopback <= 1'b0;
      tx_only <= 1'b0;
    end else if (bist_valid && bist_req == EBM_BIST_RETIMED) begin
      retimed_loopback <= 1'b1;
      tx_only <= 1'b0;
    end else if (bist_valid && bist_req == EBM_BIST_TXONLY) begin
      retimed_loopback <= 1'b0;
      tx_only <= 1'b1;
    end else if (bist_valid) begin
      // No analog loopback: any other request keeps the mode
      retimed_loopback <= retimed_loopback;
      tx_only <= tx_only;
    end
  end

  // ------------------------------------------------------------
  // Clean-run timer in loopback
  // ------------------------------------------------------------
  logic [11:0] clean_cnt_q;

  always_ff @(posedge sys_clk) begin
    // Leaving the mode drops the pass on the same edge, not one late
    if (!rst_n || !retimed_loopback || lb_exit || (frame.frame_end && frame.crc_bad)) begin
      clean_cnt_q <= '0;
      loopback_pass <= 1'b0;
    end else if (tick && clean_cnt_q != LB_CLEAN_TICKS) begin
      clean_cnt_q <= clean_cnt_q + 12'h001;
    end else if (clean_cnt_q == LB_CLEAN_TICKS) begin
      loopback_pass <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_ready;
    @(posedge sys_clk) disable iff (!rst_n)
    link_ready_indication |-> $past(phy_st.comm_est & phy_st.rx_sync & phy_st.tx_valid);
  endproperty
  a_ready: assert property (p_ready) else $error("ready without link");

  property p_rst_det;
    @(posedge sys_clk) disable iff (!rst_n)
    oob_reset_seen |=> reset_detected && !retimed_loopback && !tx_only;
  endproperty
  a_rst_det: assert property (p_rst_det) else $error("oob reset ignored");

  property p_one_per_win;
    @(posedge sys_clk) disable iff (!rst_n)
    (win_open_q && rx_err.invalid_word && !rdy_rise) |=> $stable(burst_count) || $past(per_expire && restart_on_period);
  endproperty
  a_one_per_win: assert property (p_one_per_win) else $error("burst counted twice");

  property p_thresh;
    @(posedge sys_clk) disable iff (!rst_n)
    hit |=> thresh_flag && burst_count == 5'h00;
  endproperty
  a_thresh: assert property (p_thresh) else $error("threshold not flagged");

  property p_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    (thresh_flag && !thresh_clr) |=> thresh_flag;
  endproperty
  a_hold: assert property (p_hold) else $error("flag dropped");

  property p_restart;
    @(posedge sys_clk) disable iff (!rst_n)
    rdy_rise |=> burst_count == 5'h00 && !win_open_q;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart on ready");

  property p_crc;
    @(posedge sys_clk) disable iff (!rst_n)
    (frame.frame_end && frame.crc_bad) |=> crc_fail ##1 !loopback_pass;
  endproperty
  a_crc: assert property (p_crc) else $error("crc failure missed");

  property p_enter;
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(retimed_loopback) |-> $past(bist_valid && bist_req == EBM_BIST_RETIMED);
  endproperty
  a_enter: assert property (p_enter) else $error("loopback without request");

  property p_pass;
    @(posedge sys_clk) disable iff (!rst_n)
    loopback_pass |-> retimed_loopback && clean_cnt_q == LB_CLEAN_TICKS;
  endproperty
  a_pass: assert property (p_pass) else $error("early pass");

  sequence s_lb_leave;
    retimed_loopback && lb_exit;
  endsequence

  property p_leave;
    @(posedge sys_clk) disable iff (!rst_n)
    s_lb_leave |=> !retimed_loopback && !loopback_pass;
  endproperty
  a_leave: assert property (p_leave) else $error("pass outlived loopback exit");

  property p_byte_err;
    @(posedge sys_clk) disable iff (!rst_n)
    ((rx_err.byte_mismatch || rx_err.code_violation) && byte_err_count != BYTE_ERR_MAX)
      |=> byte_err_count == $past(byte_err_count) + 32'h00000001;
  endproperty
  a_byte_err: assert property (p_byte_err) else $error("byte error not counted");

  property p_period;
    @(posedge sys_clk) disable iff (!rst_n)
    (per_expire && restart_on_period && !hit && !rdy_rise) |=> burst_count == {4'h0, $past(burst_start)};
  endproperty
  a_period: assert property (p_period) else $error("period restart missed");

  property p_tx_only;
    @(posedge sys_clk) disable iff (!rst_n)
    (bist_valid && bist_req == EBM_BIST_TXONLY && !oob_reset_seen) |=> tx_only && !retimed_loopback;
  endproperty
  a_tx_only: assert property (p_tx_only) else $error("transmit-only not entered");
endmodule : ebm_monitor
`default_nettype wire

// *** design/ebm_pkg.sv ***
// Purpose: Shared constants and carriers for the error burst monitor and loopback control
// Assumes: 20 MHz system clock
// Notes: Prescalers set the tick rate; all long times count ticks
package ebm_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam logic [15:0] TICK_DIV_RST = 16'(TICK_CYCLES - 1);
  localparam int unsigned BURST_MS = 1500;
  localparam logic [11:0] BURST_TICKS_RST = 12'(BURST_MS / TICK_MS);
  localparam int unsigned PERIOD_S = 300;
  localparam logic [18:0] PERIOD_TICKS_RST = 19'(PERIOD_S * 1000 / TICK_MS);
  localparam int unsigned LB_CLEAN_MS = 1000;
  localparam logic [11:0] LB_CLEAN_TICKS = 12'(LB_CLEAN_MS / TICK_MS);

  // ------------------------------------------------------------
  // Counts
  // ------------------------------------------------------------
  localparam logic [4:0] THRESH_COUNT = 5'h0f;
  localparam logic [4:0] BURST_CNT_MAX = 5'h1f;
  localparam logic [31:0] BYTE_ERR_MAX = 32'hffffffff;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    EBM_BIST_NONE,
    EBM_BIST_RETIMED,
    EBM_BIST_TXONLY
  } ebm_bist_t;

  typedef struct packed {
    logic comm_est;
    logic rx_sync;
    logic tx_valid;
  } ebm_phy_st_t;

  typedef struct packed {
    logic byte_mismatch;
    logic code_violation;
    logic invalid_word;
  } ebm_rx_err_t;

  typedef struct packed {
    logic frame_end;
    logic crc_bad;
  } ebm_frame_t;

endpackage : ebm_pkg

// *** design/ebm_tick.sv ***
// Purpose: Programmable prescaler producing a one-cycle tick
// Assumes: Synchronous active-low reset
// Notes: Reload value is compared against the count on every cycle, not only at each wrap
`timescale 1ns/10ps
`default_nettype none
module ebm_tick #(
  parameter int W = 16
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic [W-1:0] reload,
  output logic tick
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge sys_clk) begin
    if (!rst_n || clr) begin
      cnt_q <= '0;
      tick <= 1'b0;
    end else if (cnt_q >= reload) begin
      cnt_q <= '0;
      tick <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule : ebm_tick
`default_nettype wire

// *** verification/ebm_peer_model.sv ***
// Purpose: Peer port model driving link status, receive errors, frames, OOB and BIST requests
// Assumes: Every change lands 1 ns after a rising edge of sys_clk
// Notes: Idle qualifiers carry junk, so a monitor that reads them unqualified shows up
`timescale 1ns/10ps
`default_nettype none
module ebm_peer_model (
  input wire logic sys_clk,
  output var ebm_pkg::ebm_phy_st_t phy_st,
  output var ebm_pkg::ebm_rx_err_t rx_err,
  output var ebm_pkg::ebm_frame_t frame,
  output var logic oob_reset_seen,
  output var logic bist_valid,
  output var ebm_pkg::ebm_bist_t bist_req
);
  import ebm_pkg::*;

  initial begin
    phy_st = '0;
    rx_err = '0;
    frame = 2'h1;
    oob_reset_seen = 1'b0;
    bist_valid = 1'b0;
    bist_req = EBM_BIST_TXONLY;
  end

  task automatic set_phy(input ebm_phy_st_t s);
    @(posedge sys_clk);
    #1;
    phy_st = s;
  endtask : set_phy

  // ----------------------------------------
  // One-cycle event toward the monitor
  // ----------------------------------------
  task automatic send(input ebm_rx_err_t e, input ebm_frame_t f, input logic oob, input logic bv,
                      input ebm_bist_t b);
    @(posedge sys_clk);
    #1;
    rx_err = e;
    frame = f;
    oob_reset_seen = oob;
    bist_valid = bv;
    bist_req = b;
    @(posedge sys_clk);
    #1;
    rx_err = '0;
    frame = 2'h1;
    oob_reset_seen = 1'b0;
    bist_valid = 1'b0;
    bist_req = EBM_BIST_TXONLY;
  endtask : send
endmodule : ebm_peer_model
`default_nettype wire

// *** verification/tb_error_burst_monitor_loopback.sv ***
// Purpose: Self-checking bench for the error burst monitor and loopback control
// Assumes: 2-cycle tick, 4-tick burst window, peer model on the far side
// Notes: Burst spacing keeps clear of the window edge, whose tick phase is loose
`timescale 1ns/10ps
`default_nettype none
module tb_error_burst_monitor_loopback;
  import ebm_pkg::*;
  localparam ebm_rx_err_t INV = 3'h1;
  localparam ebm_rx_err_t CV = 3'h2;
  localparam ebm_rx_err_t MIS = 3'h4;
  localparam ebm_frame_t NOF = 2'h0;
  localparam ebm_frame_t GOOD = 2'h2;
  localparam ebm_frame_t BAD = 2'h3;
  logic sys_clk, rst_n, oob_reset_seen, bist_valid, restart_on_period, thresh_clr;
  ebm_phy_st_t phy_st;
  ebm_rx_err_t rx_err;
  ebm_frame_t frame;
  ebm_bist_t bist_req;
  logic [15:0] tick_div;
  logic [11:0] burst_ticks;
  logic [18:0] period_ticks;
  logic link_ready_indication, reset_detected, thresh_flag, crc_fail, retimed_loopback, tx_only, loopback_pass;
  logic [4:0] burst_count;
  logic [31:0] byte_err_count, b0;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [3:0] rows [8] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h8, 4'ha, 4'hc, 4'hf};

  ebm_monitor dut (.sys_clk(sys_clk), .rst_n(rst_n), .phy_st(phy_st), .rx_err(rx_err), .frame(frame),
    .oob_reset_seen(oob_reset_seen), .bist_valid(bist_valid), .bist_req(bist_req), .tick_div(tick_div),
    .burst_ticks(burst_ticks), .period_ticks(period_ticks), .restart_on_period(restart_on_period),
    .thresh_clr(thresh_clr), .link_ready_indication(link_ready_indication), .reset_detected(reset_detected),
    .thresh_flag(thresh_flag), .burst_count(burst_count), .byte_err_count(byte_err_count), .crc_fail(crc_fail),
    .retimed_loopback(retimed_loopback), .tx_only(tx_only), .loopback_pass(loopback_pass));
  ebm_peer_model peer (.sys_clk(sys_clk), .phy_st(phy_st), .rx_err(rx_err), .frame(frame),
    .oob_reset_seen(oob_reset_seen), .bist_valid(bist_valid), .bist_req(bist_req));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    if (mismatches == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  // Two invalid words inside one window, then a quiet gap well past it
  task automatic burst();
    peer.send(INV, NOF, 1'b0, 1'b0, EBM_BIST_TXONLY);
    peer.send(INV, NOF, 1'b0, 1'b0, EBM_BIST_TXONLY);
    repeat (30) @(posedge sys_clk);
    #1;
  endtask : burst

  task automatic ev(input ebm_frame_t f, input logic oob, input logic bv, input ebm_bist_t b);
    peer.send('0, f, oob, bv, b);
  endtask : ev

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 8000) begin
      mismatches++;
      wrap_up();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    tick_div = 16'h0001;
    burst_ticks = 12'h004;
    period_ticks = 19'h00fa0;
    restart_on_period = 1'b0;
    thresh_clr = 1'b0;
    repeat (20) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    check("outputs", {reset_detected, thresh_flag, burst_count, crc_fail, retimed_loopback, tx_only}, 32'h0);
    peer.set_phy(3'h7);
    b0 = byte_err_count;
    peer.send(MIS, NOF, 1'b0, 1'b0, EBM_BIST_TXONLY);
    peer.send(CV, NOF, 1'b0, 1'b0, EBM_BIST_TXONLY);
    check("byte_err_count", byte_err_count, b0 + 32'h2);
    for (int i = 0; i < 8; i++) begin
      peer.set_phy(rows[i][3:1]);
      @(posedge sys_clk);
      #1;
      check("link_ready_indication", link_ready_indication, 32'(rows[i][0]));
    end
    repeat (3) @(posedge sys_clk);
    for (int i = 1; i < 15; i++) begin
      burst();
      check("burst_count", burst_count, 32'(i));
    end
    check("thresh_flag", thresh_flag, 32'h0);
    burst();
    check("thresh_flag", thresh_flag, 32'h1);
    check("burst_count", burst_count, 32'h0);
    burst();
    check("thresh_flag", thresh_flag, 32'h1);
    @(posedge sys_clk);
    #1;
    thresh_clr = 1'b1;
    @(posedge sys_clk);
    #1;
    thresh_clr = 1'b0;
    check("thresh_flag", thresh_flag, 32'h0);
    peer.set_phy(3'h6);
    peer.set_phy(3'h7);
    repeat (3) @(posedge sys_clk);
    #1;
    check("burst_count", burst_count, 32'h0);
    burst();
    check("burst_count", burst_count, 32'h1);
    restart_on_period = 1'b1;
    period_ticks = 19'h00032;
    repeat (300) @(posedge sys_clk);
    #1;
    check("burst_count", burst_count, 32'h0);
    peer.set_phy(3'h6);
    peer.set_phy(3'h7);
    peer.send(INV, NOF, 1'b0, 1'b0, EBM_BIST_TXONLY);
    repeat (97) @(posedge sys_clk);
    #1;
    check("burst_count", burst_count, 32'h1);
    repeat (5) @(posedge sys_clk);
    #1;
    check("burst_count", burst_count, 32'h0);
    restart_on_period = 1'b0;
    ev(BAD, 1'b0, 1'b0, EBM_BIST_TXONLY);
    check("crc_fail", crc_fail, 32'h1);
    ev(GOOD, 1'b0, 1'b0, EBM_BIST_TXONLY);
    check("crc_fail", crc_fail, 32'h0);
    ev(NOF, 1'b0, 1'b1, EBM_BIST_NONE);
    check("retimed_loopback", retimed_loopback, 32'h0);
    ev(NOF, 1'b1, 1'b1, EBM_BIST_RETIMED);
    check("modes", {reset_detected, retimed_loopback}, 32'h2);
    ev(NOF, 1'b0, 1'b1, EBM_BIST_RETIMED);
    check("retimed_loopback", retimed_loopback, 32'h1);
    for (int i = 0; i < 9; i++) begin
      ev(GOOD, 1'b0, 1'b0, EBM_BIST_TXONLY);
      repeat (98) @(posedge sys_clk);
    end
    #1;
    check("loopback_pass", loopback_pass, 32'h0);
    repeat (1200) @(posedge sys_clk);
    #1;
    check("loop state", {retimed_loopback, loopback_pass}, 32'h3);
    ev(BAD, 1'b0, 1'b0, EBM_BIST_TXONLY);
    check("bad frame", {retimed_loopback, loopback_pass, crc_fail}, 32'h5);
    ev(NOF, 1'b1, 1'b0, EBM_BIST_TXONLY);
    check("loop exit", {reset_detected, retimed_loopback, loopback_pass}, 32'h4);
    ev(NOF, 1'b0, 1'b1, EBM_BIST_TXONLY);
    check("tx_only", tx_only, 32'h1);
    wrap_up();
  end
endmodule : tb_error_burst_monitor_loopback
`default_nettype wire
